// File: design/test_point_pkg.sv
/*
 test point port constants: strap codes, pin count, clock debug rates and
 the divider figures derived from the 125 MHz core clock.
 assumes a single synchronous clock domain.
*/
package test_point_pkg;
	localparam int          PIN_COUNT     = 8;
	localparam int          CODE_WIDTH    = 3;
	localparam int          SEL_WIDTH     = 2;
	localparam logic [2:0]  CODE_QUIET    = 3'h0;
	localparam logic [2:0]  CODE_CLOCKS   = 3'h2;
	localparam logic [7:0]  STRAP_RESET   = 8'h00;
	// clock debug output selection codes, as software may program them
	localparam logic [1:0]  SEL_STRAP     = 2'h0;
	localparam logic [1:0]  SEL_QUIET     = 2'h1;
	localparam logic [1:0]  SEL_CLOCKS    = 2'h2;
	// clock debug rates in kHz and core clock in kHz
	localparam int          CORE_KHZ      = 125000;
	localparam int          FAST_KHZ      = 60000;
	localparam int          MID_KHZ       = 30000;
	localparam int          SLOW_KHZ      = 7500;
	// toggle periods in core cycles: half period rounded down, at least one
	localparam int          FAST_HALF     = (CORE_KHZ / FAST_KHZ / 2 > 0) ?
	                                        CORE_KHZ / FAST_KHZ / 2 : 1;
	localparam int          MID_HALF      = (CORE_KHZ / MID_KHZ / 2 > 0) ?
	                                        CORE_KHZ / MID_KHZ / 2 : 1;
	localparam int          SLOW_HALF     = (CORE_KHZ / SLOW_KHZ / 2 > 0) ?
	                                        CORE_KHZ / SLOW_KHZ / 2 : 1;
	localparam logic [7:0]  CLOCKS_LEVELS = 8'h68;
	localparam logic [7:0]  CLOCKS_DRIVE  = 8'hFF;
	localparam int          DIV_WIDTH     = 8;
endpackage : test_point_pkg

// File: design/test_point_port.sv
/*
 eight-pin strap and debug output port.
 assumes pins arrive synchronous to clk, pulldowns sit in the pad ring,
 and resetn is the synchronous active-low reset seen on the reset input.
*/
`timescale 1ns/100ps
module test_point_port
	import test_point_pkg::*;
#(
	parameter int VAR_HALF_DEFAULT = 3
) (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic [test_point_pkg::PIN_COUNT-1:0] test_point_pins_in,
	output logic      [test_point_pkg::PIN_COUNT-1:0] test_point_pins_out,
	output logic      [test_point_pkg::PIN_COUNT-1:0] test_point_pins_oe,
	input  wire logic [test_point_pkg::SEL_WIDTH-1:0] sw_select,
	input  wire logic                          sw_select_we,
	input  wire logic [test_point_pkg::DIV_WIDTH-1:0] sw_var_half,
	output logic      [test_point_pkg::CODE_WIDTH-1:0] strap_code,
	output logic                               out_active
);
	import test_point_pkg::*;

	typedef enum logic [2:0] {
		ST_RESET  = 3'h1,
		ST_QUIET  = 3'h2,
		ST_CLOCKS = 3'h4
	} mode_t;

	mode_t                  mode_q, mode_d;
	logic [PIN_COUNT-1:0]   strap_q, strap_d;
	logic [SEL_WIDTH-1:0]   sel_q, sel_d;
	logic                   in_reset_q;
	logic [DIV_WIDTH-1:0]   c_fast_q, c_mid_q, c_slow_q, c_var_q;
	logic [DIV_WIDTH-1:0]   c_fast_d, c_mid_d, c_slow_d, c_var_d;
	logic [3:0]             clk_q, clk_d;
	logic [DIV_WIDTH-1:0]   var_half;
	logic                   release_edge;

	// the release is seen one cycle after resetn rises; pins are sampled
	// there and nowhere else, so later strap changes are ignored
	assign release_edge = in_reset_q;
	assign var_half     = (sw_var_half == '0) ? DIV_WIDTH'(VAR_HALF_DEFAULT) : sw_var_half;

	// ST_RESET lasts into the release cycle so the mode comes from the same pin
	// levels that the strap register takes; a write in that cycle is dropped
	always_comb begin
		strap_d = strap_q;
		sel_d   = sel_q;
		mode_d  = mode_q;
		if (release_edge) begin
			strap_d = test_point_pins_in;
			sel_d   = SEL_STRAP;
		end else if (sw_select_we) begin
			sel_d = sw_select;
		end
		case (mode_q)
			ST_RESET: begin
				mode_d = (release_edge && test_point_pins_in[2:0] == CODE_CLOCKS) ?
				         ST_CLOCKS : ST_QUIET;
			end
			ST_QUIET, ST_CLOCKS: begin
				if (sel_q == SEL_QUIET)
					mode_d = ST_QUIET;
				else if (sel_q == SEL_CLOCKS)
					mode_d = ST_CLOCKS;
				else
					mode_d = (strap_q[2:0] == CODE_CLOCKS) ? ST_CLOCKS : ST_QUIET;
			end
			default: mode_d = ST_RESET;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			in_reset_q <= 1'b1;
			strap_q    <= STRAP_RESET;
			sel_q      <= SEL_STRAP;
			mode_q     <= ST_RESET;
		end else begin
			in_reset_q <= 1'b0;
			strap_q    <= strap_d;
			sel_q      <= sel_d;
			mode_q     <= mode_d;
		end
	end

	// clock dividers toggle on half-period counts; rates are approximate
	// because 125 MHz does not divide evenly into 60, 30 or 7.5 MHz
	// the variable clock reads sw_var_half every cycle, so a new half period
	// applies to the running count; a count already at or past it wraps on the next clock
	always_comb begin
		c_fast_d = c_fast_q + 1'b1;
		c_mid_d  = c_mid_q + 1'b1;
		c_slow_d = c_slow_q + 1'b1;
		c_var_d  = c_var_q + 1'b1;
		clk_d    = clk_q;
		if (c_fast_q >= DIV_WIDTH'(FAST_HALF - 1)) begin
			c_fast_d = '0;
			clk_d[0] = ~clk_q[0];
		end
		if (c_mid_q >= DIV_WIDTH'(MID_HALF - 1)) begin
			c_mid_d  = '0;
			clk_d[1] = ~clk_q[1];
		end
		if (c_var_q >= var_half - 1'b1) begin
			c_var_d  = '0;
			clk_d[2] = ~clk_q[2];
		end
		if (c_slow_q >= DIV_WIDTH'(SLOW_HALF - 1)) begin
			c_slow_d = '0;
			clk_d[3] = ~clk_q[3];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			c_fast_q <= '0;
			c_mid_q  <= '0;
			c_slow_q <= '0;
			c_var_q  <= '0;
			clk_q    <= 4'h0;
		end else begin
			c_fast_q <= c_fast_d;
			c_mid_q  <= c_mid_d;
			c_slow_q <= c_slow_d;
			c_var_q  <= c_var_d;
			clk_q    <= clk_d;
		end
	end

	// output data registered as levels; enables follow the mode register
	// dividers run in every mode and only the enables gate the pins, so a
	// software switch to clock debug shows clocks with no start-up glitch
	always_comb begin
		test_point_pins_out = CLOCKS_LEVELS;
		test_point_pins_out[0] = clk_q[0];
		test_point_pins_out[1] = clk_q[1];
		test_point_pins_out[2] = clk_q[2];
		test_point_pins_out[7] = clk_q[3];
		if (mode_q == ST_CLOCKS)
			test_point_pins_oe = CLOCKS_DRIVE;
		else
			test_point_pins_oe = '0;
	end

	assign strap_code = strap_q[2:0];
	assign out_active = (mode_q == ST_CLOCKS);

	// reset-side checks carry no disable so that they see the reset cycles too
	AST_NO_DRIVE_IN_RESET: assert property (@(posedge clk)
		!resetn |=> test_point_pins_oe == '0)
		else $error("pins driven during reset");
	AST_STRAP_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)
		$past(!resetn) |=> strap_code == $past(test_point_pins_in[2:0]))
		else $error("strap not captured at release");
	AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		!$past(!resetn) && !in_reset_q |=> $stable(strap_code))
		else $error("strap changed without reset");
	AST_QUIET_DEFAULT: assert property (@(posedge clk) disable iff (!resetn)
		(sel_q == SEL_STRAP && !in_reset_q && strap_q[2:0] != CODE_CLOCKS)
		|=> test_point_pins_oe == '0)
		else $error("outputs driven in quiet mode");
	AST_CLOCKS_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
		(sel_q == SEL_STRAP && !in_reset_q && strap_q[2:0] == CODE_CLOCKS)
		|=> test_point_pins_oe == CLOCKS_DRIVE)
		else $error("clock debug outputs not driven");
	AST_FIXED_LEVELS: assert property (@(posedge clk) disable iff (!resetn)
		out_active |-> test_point_pins_out[3] && !test_point_pins_out[4]
		&& test_point_pins_out[5] && test_point_pins_out[6])
		else $error("fixed levels wrong");
	AST_FAST_TOGGLE: assert property (@(posedge clk) disable iff (!resetn)
		$rose(clk_q[0]) |=> $fell(clk_q[0]))
		else $error("fast clock half period wrong");
	AST_SW_OVERRIDE: assert property (@(posedge clk) disable iff (!resetn)
		(sw_select_we && sw_select == SEL_QUIET && !in_reset_q)
		|=> ##1 test_point_pins_oe == '0)
		else $error("software quiet selection ignored");
	AST_OTHER_CODE: assert property (@(posedge clk) disable iff (!resetn)
		(in_reset_q && test_point_pins_in[2:0] != CODE_CLOCKS)
		|=> test_point_pins_oe == '0)
		else $error("undefined code drove outputs");
	AST_RESET_MODE: assert property (@(posedge clk)
		!resetn |=> !out_active)
		else $error("clock debug mode kept through reset");
	AST_FAST_FALL: assert property (@(posedge clk) disable iff (!resetn)
		$fell(clk_q[0]) |=> $rose(clk_q[0]))
		else $error("fast clock low phase wrong");
	AST_MID_HALF: assert property (@(posedge clk) disable iff (!resetn)
		$rose(clk_q[1]) |-> clk_q[1] [*2] ##1 !clk_q[1])
		else $error("mid clock half period wrong");
	AST_SLOW_HALF: assert property (@(posedge clk) disable iff (!resetn)
		$rose(clk_q[3]) |-> clk_q[3] [*8] ##1 !clk_q[3])
		else $error("slow clock half period wrong");
	AST_SW_CLOCKS: assert property (@(posedge clk) disable iff (!resetn)
		(sw_select_we && sw_select == SEL_CLOCKS && !in_reset_q)
		|=> ##1 test_point_pins_oe == CLOCKS_DRIVE)
		else $error("software clock selection ignored");
	AST_CAPTURE_SEL: assert property (@(posedge clk) disable iff (!resetn)
		in_reset_q |=> sel_q == SEL_STRAP)
		else $error("selection not back to strap default at release");

	COV_QUIET:  cover property (@(posedge clk) in_reset_q && test_point_pins_in[2:0] == CODE_QUIET);
	COV_CLOCKS: cover property (@(posedge clk) in_reset_q && test_point_pins_in[2:0] == CODE_CLOCKS);
	COV_SW_ON:  cover property (@(posedge clk) sw_select_we && sw_select == SEL_CLOCKS);
	COV_SW_OFF: cover property (@(posedge clk) sw_select_we && sw_select == SEL_QUIET);
	COV_OTHER:  cover property (@(posedge clk) in_reset_q && resetn
		&& test_point_pins_in[2:0] != CODE_QUIET && test_point_pins_in[2:0] != CODE_CLOCKS);
endmodule : test_point_port

// File: tb/tp_board.sv
/*
 board side of the test point port: jumpered pullups on the low three pins
 and a probe that only listens. assumes pad pulldowns inside the device.
*/
`timescale 1ns/100ps
module tp_board (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [2:0] jumper,
	output logic      [7:0] pad
);
	// undriven pins without a jumper fall to the pulldown; upper five stay open on the board
	assign pad = (pin_oe & pin_out) | (~pin_oe & {5'h00, jumper});
endmodule : tp_board

// File: tb/tb.sv
/*
 self-checking bench for the test point port: strap capture for every code,
 late strap changes, software selection and fixed debug levels.
 assumes the board model tp_board and a 125 MHz clock.
*/
`timescale 1ns/100ps
module tb;
	import test_point_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  pad, pout, poe;
	logic [2:0]  jumper = 3'h0;
	logic [1:0]  sw_select = 2'h0;
	logic        sw_select_we = 1'b0;
	logic [7:0]  sw_var_half = 8'h00;
	logic [2:0]  strap_code;
	logic        out_active, chk = 1'b0, p0;
	logic [31:0] rnd = 32'h541E3739;
	logic [11:0] q[$];
	logic [11:0] e;
	int          err_total = 0;
	int          n_tests = 0;
	always #4 clk = ~clk;
	test_point_port dut (.clk(clk), .resetn(resetn), .test_point_pins_in(pad),
		.test_point_pins_out(pout), .test_point_pins_oe(poe), .sw_select(sw_select),
		.sw_select_we(sw_select_we), .sw_var_half(sw_var_half),
		.strap_code(strap_code), .out_active(out_active));
	tp_board board (.pin_out(pout), .pin_oe(poe), .jumper(jumper), .pad(pad));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic cmp(input string nm, input logic [11:0] ex, input logic [11:0] g);
		n_tests++;
		if (g !== ex) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, g);
		end
	endtask : cmp
	task automatic complete_run();
		$display("tests %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	// note the expected state; the monitor compares at the next falling edge
	task automatic expect_state(input logic [11:0] ex);
		q.push_back(ex);
		chk <= 1'b1;
		@(posedge clk);
		chk <= 1'b0;
		@(posedge clk);
	endtask : expect_state
	task automatic sw_write(input logic [1:0] s);
		sw_select <= s;
		sw_select_we <= 1'b1;
		@(posedge clk);
		sw_select_we <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : sw_write
	// cycles between two changes of one pin; a stuck pin runs out the bound
	task automatic half_period(input string nm, input int b, input int ex);
		logic v;
		int   n;
		@(negedge clk);
		v = pout[b];
		n = 0;
		while (pout[b] == v && n < 300) begin
			@(negedge clk);
			n++;
		end
		v = pout[b];
		n = 0;
		while (pout[b] == v && n < 300) begin
			@(negedge clk);
			n++;
		end
		cmp(nm, 12'(ex), 12'(n));
	endtask : half_period
	always @(negedge clk) begin
		if (chk) begin
			cmp("oe code active", q.pop_front(), {poe, strap_code, out_active});
		end
	end
	initial begin
		#400000;
		err_total++;
		complete_run();
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			resetn <= 1'b0;
			jumper <= i[2:0];
			repeat (4) @(posedge clk);
			@(negedge clk);
			cmp("oe in reset", 12'h000, {poe, 4'h0});
			@(posedge clk);
			rnd = xs(rnd);
			sw_var_half <= (i == 0) ? 8'h00 : rnd[7:0];
			resetn <= 1'b1;
			repeat (3) @(posedge clk);
			e = {(i == 2) ? 8'hFF : 8'h00, i[2:0], i == 2};
			expect_state(e);
			jumper <= rnd[10:8] ^ i[2:0] ^ 3'h7;
			repeat (3) @(posedge clk);
			expect_state(e);
			sw_write(2'h1);
			expect_state({8'h00, i[2:0], 1'b0});
			sw_write(2'h2);
			expect_state({8'hFF, i[2:0], 1'b1});
			@(negedge clk);
			cmp("fixed levels", 12'h068, {4'h0, pout & 8'h78});
			p0 = pout[0];
			@(negedge clk);
			cmp("pin0 toggles", {11'h000, ~p0}, {11'h000, pout[0]});
			half_period("pin1 half period", 1, MID_HALF);
			half_period("pin7 half period", 7, SLOW_HALF);
			half_period("pin2 half period", 2, (sw_var_half == 8'h00) ? 3 : int'(sw_var_half));
			@(posedge clk);
			sw_write(2'h3);
			expect_state(e);
			$display("test strap code %0d done", i);
		end
		complete_run();
	end
endmodule : tb
